// ==== design/fiap_defines.svh ====
// Constants for the flash programming sequencer: offsets, fields, reset values, timing.
`ifndef FIAP_DEFINES_SVH
`define FIAP_DEFINES_SVH

// Register offsets.
`define FIAP_OFS_CTRL0 8'h00
`define FIAP_OFS_CTRL1 8'h01
`define FIAP_OFS_ADDR_LOW 8'h02
`define FIAP_OFS_ADDR_HIGH 8'h03
`define FIAP_OFS_PD_LOW 8'h04
`define FIAP_OFS_PD_HIGH 8'h05
`define FIAP_OFS_KEY1_LOW 8'h06
`define FIAP_OFS_KEY1_HIGH 8'h07
`define FIAP_OFS_KEY2_LOW 8'h08
`define FIAP_OFS_KEY2_HIGH 8'h09
`define FIAP_OFS_KEY3_LOW 8'h0A
`define FIAP_OFS_KEY3_HIGH 8'h0B

// Control register 0 fields.
`define FIAP_C0_MODE_HI 6
`define FIAP_C0_MODE_LO 4
`define FIAP_C0_PROTECT 3
`define FIAP_C0_ENABLED 2
`define FIAP_C0_READ_EN 1
// Control register 1 fields.
`define FIAP_C1_OP_TRIG 0
`define FIAP_C1_RD_TRIG 1
`define FIAP_C1_CLR_BUF 2

// Mode codes.
`define FIAP_MODE_PROG 3'h0
`define FIAP_MODE_ERASE 3'h1
`define FIAP_MODE_READ 3'h3
`define FIAP_MODE_UNLOCK 3'h6

// Unlock key bytes, key registers 1 low to 3 high.
`define FIAP_KEY1_LOW 8'h00
`define FIAP_KEY1_HIGH 8'h04
`define FIAP_KEY2_LOW 8'h0D
`define FIAP_KEY2_HIGH 8'h09
`define FIAP_KEY3_LOW 8'hC3
`define FIAP_KEY3_HIGH 8'h40

// Reset values.
`define FIAP_RST_BYTE 8'h00
`define FIAP_RST_WORD 16'h0000

// Timing.
`define FIAP_CLK_HZ 25000000
`define FIAP_OP_TIME_NS 2200000
`define FIAP_OP_CYCLES ((`FIAP_OP_TIME_NS / 1000) * (`FIAP_CLK_HZ / 1000000))
`define FIAP_READ_CYCLES 3
`define FIAP_UNLOCK_CYCLES 1024

`endif

// ==== design/fiap_pkg.sv ====
// Types shared by the flash programming sequencer.
`default_nettype none
package fiap_pkg;

    // Sequencer states.
    typedef enum logic [2:0] {
        FIAP_IDLE,
        FIAP_ERASE,
        FIAP_PROG,
        FIAP_WAIT,
        FIAP_READ
    } fiap_state_e;

    // Command bundle toward the flash array.
    typedef struct packed {
        logic erase;
        logic prog;
        logic rd;
        logic [12:0] addr;
        logic [15:0] wdata;
    } fiap_flash_req_s;

    // Software register port request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fiap_reg_req_s;

endpackage
`default_nettype wire

// ==== design/fiap_timer.sv ====
// Down counter that times an operation and pulses when it expires.
`default_nettype none
module fiap_timer #(
    parameter int W = 17
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Control.
    input wire logic load,
    input wire logic [W-1:0] load_val,
    // Status.
    output logic busy,
    output logic done
);
    logic [W-1:0] cnt_r;

    initial begin
        if (W < 2) $error("fiap_timer: width too small");
    end

    // Count down from the loaded value to zero.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
        end else if (load) begin
            cnt_r <= load_val;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // Done marks the last counted cycle.
    assign busy = (cnt_r != '0);
    assign done = (cnt_r == {{(W-1){1'b0}}, 1'b1}) && !load;
endmodule
`default_nettype wire

// ==== design/fiap_wbuf.sv ====
// Page write buffer: one word and one valid bit per entry.
`default_nettype none
module fiap_wbuf #(
    parameter int DEPTH = 32,
    parameter int W = 16
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Load side.
    input wire logic wr_en,
    input wire logic [$clog2(DEPTH)-1:0] wr_idx,
    input wire logic [W-1:0] wr_data,
    input wire logic clr,
    // Drain side.
    input wire logic [$clog2(DEPTH)-1:0] rd_idx,
    output logic [W-1:0] rd_data,
    output logic rd_valid
);
    logic [W-1:0] mem_r [DEPTH];
    logic [DEPTH-1:0] valid_r;

    initial begin
        if (DEPTH != 32) $error("fiap_wbuf: page holds 32 words");
    end

    // One entry per page word; a clear empties every entry.
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                mem_r[i] <= '0;
                valid_r[i] <= 1'b0;
            end else if (clr) begin
                valid_r[i] <= 1'b0;
            end else if (wr_en && wr_idx == i) begin
                mem_r[i] <= wr_data;
                valid_r[i] <= 1'b1;
            end
        end
    end

    assign rd_data = mem_r[rd_idx];
    assign rd_valid = valid_r[rd_idx];
endmodule
`default_nettype wire

// ==== design/fiap_top.sv ====
// Flash programming sequencer: registers, unlock, erase, page program and read.
`default_nettype none
`include "fiap_defines.svh"
module fiap_top #(
    parameter int OP_CYCLES = `FIAP_OP_CYCLES,
    parameter int UNLOCK_CYCLES = `FIAP_UNLOCK_CYCLES,
    parameter int PAGE_WORDS = 32
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Register port.
    input wire fiap_pkg::fiap_reg_req_s reg_req,
    output logic [7:0] reg_rdata,
    // Flash array.
    output fiap_pkg::fiap_flash_req_s flash_req,
    input wire logic [15:0] flash_rdata,
    // CPU hold.
    output logic cpu_stall
);
    import fiap_pkg::*;
    // This block only commands the array.

    // Timer and page index widths.
    localparam int TW = 17;
    localparam int IW = $clog2(PAGE_WORDS);

    // Refuse values the counters cannot serve.
    initial begin
        if (PAGE_WORDS != 32) $error("fiap_top: page must be 32 words");
        if (OP_CYCLES < PAGE_WORDS + 2) $error("fiap_top: op time too short");
        if (OP_CYCLES >= (1 << TW)) $error("fiap_top: op time too long");
        if (UNLOCK_CYCLES < 2) $error("fiap_top: unlock window too short");
        if (UNLOCK_CYCLES >= (1 << TW)) $error("fiap_top: unlock window too long");
    end

    // Registers.
    fiap_state_e state_r;
    logic [2:0] mode_r;
    logic protect_r;
    logic enabled_r;
    logic read_en_r;
    logic op_trig_r;
    logic rd_trig_r;
    logic [12:0] addr_r;
    logic [7:0] pd_low_r;
    logic [7:0] pd_high_r;
    logic [7:0] key_r [6];
    logic [IW-1:0] idx_r;
    logic [7:0] reg_rdata_r;
    fiap_flash_req_s flash_req_r;

    // Decoded accesses.
    logic wr;
    logic idle;
    logic wr_c0;
    logic wr_c1;
    logic wr_pd_high;
    logic key_ok;
    logic launch_erase;
    logic launch_prog;
    logic launch_read;
    logic clr_buf;

    // Timers and buffer.
    logic op_load;
    logic [TW-1:0] op_load_val;
    logic op_done;
    logic unl_load;
    logic unl_busy;
    logic [15:0] buf_data;
    logic buf_valid;

    // Strobes last one cycle.
    assign wr = reg_req.wr;
    assign idle = (state_r == FIAP_IDLE);
    assign wr_c0 = wr && reg_req.addr == `FIAP_OFS_CTRL0;
    assign wr_c1 = wr && reg_req.addr == `FIAP_OFS_CTRL1;
    assign wr_pd_high = wr && reg_req.addr == `FIAP_OFS_PD_HIGH;

    // Launch decode; erase and program need the unlocked flag.
    assign launch_erase = wr_c1 && idle && reg_req.wdata[`FIAP_C1_OP_TRIG]
        && enabled_r && mode_r == `FIAP_MODE_ERASE;
    assign launch_prog = wr_c1 && idle && reg_req.wdata[`FIAP_C1_OP_TRIG]
        && enabled_r && mode_r == `FIAP_MODE_PROG;
    assign launch_read = wr_c1 && idle && reg_req.wdata[`FIAP_C1_RD_TRIG]
        && read_en_r && mode_r == `FIAP_MODE_READ;
    // A clear is dropped while busy.
    assign clr_buf = wr_c1 && reg_req.wdata[`FIAP_C1_CLR_BUF];

    // Any running operation holds the CPU.
    // It rises the cycle after a launch.
    assign cpu_stall = !idle;

    // Operation timer: full operation time, or the short read time.
    // A read reuses it with a short count.
    assign op_load = launch_erase || launch_prog || launch_read;
    assign op_load_val = launch_read ? TW'(`FIAP_READ_CYCLES) : TW'(OP_CYCLES);

    fiap_timer #(.W(TW)) u_op_timer (
        .clk(clk),
        .arst_n(arst_n),
        .load(op_load),
        .load_val(op_load_val),
        .busy(),
        .done(op_done)
    );

    // Unlock window timer, started with the protect bit in unlock mode.
    // A new protect write restarts it.
    assign unl_load = wr_c0 && reg_req.wdata[`FIAP_C0_PROTECT]
        && reg_req.wdata[`FIAP_C0_MODE_HI:`FIAP_C0_MODE_LO] == `FIAP_MODE_UNLOCK;

    fiap_timer #(.W(TW)) u_unl_timer (
        .clk(clk),
        .arst_n(arst_n),
        .load(unl_load),
        .load_val(TW'(UNLOCK_CYCLES)),
        .busy(unl_busy),
        .done()
    );

    // Page write buffer indexed by the word bits of the address.
    // Loads are dropped while busy, so the drain is stable.
    fiap_wbuf #(.DEPTH(PAGE_WORDS), .W(16)) u_wbuf (
        .clk(clk),
        .arst_n(arst_n),
        .wr_en(wr_pd_high && idle),
        .wr_idx(addr_r[IW-1:0]),
        .wr_data({reg_req.wdata, pd_low_r}),
        .clr(clr_buf && idle),
        .rd_idx(idx_r),
        .rd_data(buf_data),
        .rd_valid(buf_valid)
    );

    // Mode and read enable fields of control register 0.
    // Software may only clear the enabled bit.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_r <= 3'h0;
            read_en_r <= 1'b0;
        end else if (wr_c0) begin
            mode_r <= reg_req.wdata[`FIAP_C0_MODE_HI:`FIAP_C0_MODE_LO];
            read_en_r <= reg_req.wdata[`FIAP_C0_READ_EN];
        end
    end

    // Protect bit follows the unlock window and drops when it expires.
    // It drops whatever key was written.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            protect_r <= 1'b0;
        end else if (unl_load) begin
            protect_r <= 1'b1;
        end else if (!unl_busy) begin
            protect_r <= 1'b0;
        end
    end

    // Key compare against the six key registers.
    // Keys may land before or in the window.
    assign key_ok = key_r[0] == `FIAP_KEY1_LOW && key_r[1] == `FIAP_KEY1_HIGH
        && key_r[2] == `FIAP_KEY2_LOW && key_r[3] == `FIAP_KEY2_HIGH
        && key_r[4] == `FIAP_KEY3_LOW && key_r[5] == `FIAP_KEY3_HIGH;

    // Enabled flag: set by a correct key in the window, cleared by software.
    // Set wins over a clear in one cycle.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enabled_r <= 1'b0;
        end else if (protect_r && key_ok && mode_r == `FIAP_MODE_UNLOCK) begin
            enabled_r <= 1'b1;
        end else if (wr_c0 && !reg_req.wdata[`FIAP_C0_ENABLED]) begin
            enabled_r <= 1'b0;
        end
    end

    // Key registers, one per byte.
    // Each holds its byte until overwritten.
    for (genvar k = 0; k < 6; k++) begin : g_key
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                key_r[k] <= `FIAP_RST_BYTE;
            end else if (wr && reg_req.addr == `FIAP_OFS_KEY1_LOW + 8'(k)) begin
                key_r[k] <= reg_req.wdata;
            end
        end
    end

    // Address pair; a high data byte advances it, saturating at page end.
    // Software writes beat the increment.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_r <= 13'h0000;
        end else if (wr && reg_req.addr == `FIAP_OFS_ADDR_LOW) begin
            addr_r[7:0] <= reg_req.wdata;
        end else if (wr && reg_req.addr == `FIAP_OFS_ADDR_HIGH) begin
            addr_r[12:8] <= reg_req.wdata[4:0];
        end else if (wr_pd_high && idle && addr_r[IW-1:0] != IW'(PAGE_WORDS - 1)) begin
            addr_r[IW-1:0] <= addr_r[IW-1:0] + 1'b1;
        end
    end

    // Primary data pair: written by software, filled by a read.
    // A finished read beats software writes.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pd_low_r <= `FIAP_RST_BYTE;
            pd_high_r <= `FIAP_RST_BYTE;
        end else if (state_r == FIAP_READ && op_done) begin
            pd_low_r <= flash_rdata[7:0];
            pd_high_r <= flash_rdata[15:8];
        end else if (wr && reg_req.addr == `FIAP_OFS_PD_LOW) begin
            pd_low_r <= reg_req.wdata;
        end else if (wr_pd_high) begin
            pd_high_r <= reg_req.wdata;
        end
    end

    // Erase and program trigger bit, cleared when the operation ends.
    // A launch needs idle; it never meets the end.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            op_trig_r <= 1'b0;
        end else if (launch_erase || launch_prog) begin
            op_trig_r <= 1'b1;
        end else if (state_r == FIAP_WAIT && op_done) begin
            op_trig_r <= 1'b0;
        end
    end

    // Read trigger bit, cleared once the word has landed.
    // It falls once the word is valid.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_trig_r <= 1'b0;
        end else if (launch_read) begin
            rd_trig_r <= 1'b1;
        end else if (state_r == FIAP_READ && op_done) begin
            rd_trig_r <= 1'b0;
        end
    end

    // Sequencer.
    // Empty entries send no strobe.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= FIAP_IDLE;
            idx_r <= '0;
        end else begin
            unique case (state_r)
                FIAP_IDLE: begin
                    idx_r <= '0;
                    if (launch_erase) begin
                        state_r <= FIAP_ERASE;
                    end else if (launch_prog) begin
                        state_r <= FIAP_PROG;
                    end else if (launch_read) begin
                        state_r <= FIAP_READ;
                    end
                end
                FIAP_ERASE: begin
                    // One cycle to send the erase strobe.
                    state_r <= FIAP_WAIT;
                end
                FIAP_PROG: begin
                    idx_r <= idx_r + 1'b1;
                    if (idx_r == IW'(PAGE_WORDS - 1)) begin
                        state_r <= FIAP_WAIT;
                    end
                end
                FIAP_WAIT: begin
                    if (op_done) begin
                        state_r <= FIAP_IDLE;
                    end
                end
                FIAP_READ: begin
                    if (op_done) begin
                        state_r <= FIAP_IDLE;
                    end
                end
                default: begin
                    state_r <= FIAP_IDLE;
                end
            endcase
        end
    end

    // Flash commands: one erase pulse, one word per cycle, read held.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flash_req_r <= '0;
        end else begin
            flash_req_r.erase <= (state_r == FIAP_ERASE);
            flash_req_r.prog <= (state_r == FIAP_PROG) && buf_valid;
            // The strobe spans the stalled cycles.
            flash_req_r.rd <= launch_read || (state_r == FIAP_READ && !op_done);
            if (state_r == FIAP_PROG) begin
                flash_req_r.addr <= {addr_r[12:IW], idx_r};
            end else if (state_r == FIAP_ERASE) begin
                // Erase targets the page base.
                flash_req_r.addr <= {addr_r[12:IW], IW'(0)};
            end else begin
                flash_req_r.addr <= addr_r;
            end
            flash_req_r.wdata <= buf_data;
        end
    end

    // Commands leave from flip-flops.
    assign flash_req = flash_req_r;

    // Read data, one cycle after the read strobe; unmapped reads zero.
    // Reads have no side effects.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_r <= `FIAP_RST_BYTE;
        end else if (reg_req.rd) begin
            unique case (reg_req.addr)
                `FIAP_OFS_CTRL0: reg_rdata_r <= {1'b0, mode_r, protect_r,
                    enabled_r, read_en_r, 1'b0};
                `FIAP_OFS_CTRL1: reg_rdata_r <= {6'h00, rd_trig_r, op_trig_r};
                `FIAP_OFS_ADDR_LOW: reg_rdata_r <= addr_r[7:0];
                `FIAP_OFS_ADDR_HIGH: reg_rdata_r <= {3'h0, addr_r[12:8]};
                `FIAP_OFS_PD_LOW: reg_rdata_r <= pd_low_r;
                `FIAP_OFS_PD_HIGH: reg_rdata_r <= pd_high_r;
                `FIAP_OFS_KEY1_LOW: reg_rdata_r <= key_r[0];
                `FIAP_OFS_KEY1_HIGH: reg_rdata_r <= key_r[1];
                `FIAP_OFS_KEY2_LOW: reg_rdata_r <= key_r[2];
                `FIAP_OFS_KEY2_HIGH: reg_rdata_r <= key_r[3];
                `FIAP_OFS_KEY3_LOW: reg_rdata_r <= key_r[4];
                `FIAP_OFS_KEY3_HIGH: reg_rdata_r <= key_r[5];
                default: reg_rdata_r <= 8'h00;
            endcase
        end else begin
            reg_rdata_r <= 8'h00;
        end
    end

    // Read data leave from a flip-flop.
    assign reg_rdata = reg_rdata_r;
endmodule
`default_nettype wire

// ==== design/fiap_wbuf_unused_placeholder.sv ====
// Intentionally empty file slot; holds no design.
`default_nettype none
`default_nettype wire

// ==== verification/fiap_chk.sv ====
// Port checker for the flash programming sequencer, bound to its top module.
`default_nettype none
module fiap_chk #(
    parameter int OP_CYCLES = 40,
    parameter int UNLOCK_CYCLES = 16,
    parameter int PAGE_WORDS = 32
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic arst_n,
    // Register port.
    input wire fiap_pkg::fiap_reg_req_s reg_req,
    input wire logic [7:0] reg_rdata,
    // Flash array.
    input wire fiap_pkg::fiap_flash_req_s flash_req,
    input wire logic [15:0] flash_rdata,
    // CPU hold.
    input wire logic cpu_stall
);
    timeunit 1ns;
    timeprecision 1ps;
    import fiap_pkg::*;
    int run_len;
    int prog_cnt;
    logic op_seen;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // Measures each stall period and counts the words programmed within it.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            run_len <= 0;
            prog_cnt <= 0;
            op_seen <= 1'b0;
        end else if (!cpu_stall) begin
            run_len <= 0;
            prog_cnt <= 0;
            op_seen <= 1'b0;
        end else begin
            run_len <= run_len + 1;
            prog_cnt <= prog_cnt + (flash_req.prog ? 1 : 0);
            op_seen <= op_seen | flash_req.erase | flash_req.prog;
        end
    end
    chk_erase_page_aligned: assert property (
        flash_req.erase |-> flash_req.addr[4:0] == 5'h00) else $error("erase not page aligned");
    chk_erase_single_pulse: assert property (
        flash_req.erase |=> !flash_req.erase [*8]) else $error("erase pulse repeated");
    chk_ops_stall_cpu: assert property (
        (flash_req.erase || flash_req.prog || flash_req.rd) |-> cpu_stall)
        else $error("flash command without cpu stall");
    chk_read_length: assert property (
        $rose(flash_req.rd) |-> flash_req.rd [*3] ##1 !flash_req.rd) else $error("read length wrong");
    chk_read_release: assert property (
        $fell(flash_req.rd) |-> ##[0:2] !cpu_stall) else $error("stall outlives read");
    chk_op_duration: assert property (
        $fell(cpu_stall) && op_seen |-> run_len >= OP_CYCLES - 3 && run_len <= OP_CYCLES + 1)
        else $error("erase or program time wrong");
    chk_prog_word_limit: assert property (
        prog_cnt <= PAGE_WORDS) else $error("too many words programmed");
    chk_prog_same_page: assert property (
        flash_req.prog && $past(flash_req.prog) |->
        {5'h00, flash_req.addr[12:5]} == ($past(flash_req.addr) >> 5)) else $error("page crossed");
    chk_rdata_only_after_read: assert property (
        reg_rdata != 8'h00 |-> $past(reg_req.rd)) else $error("read data without read");
endmodule
bind fiap_top fiap_chk #(
    .OP_CYCLES(OP_CYCLES),
    .UNLOCK_CYCLES(UNLOCK_CYCLES),
    .PAGE_WORDS(PAGE_WORDS)
) u_chk (
    .clk(clk),
    .arst_n(arst_n),
    .reg_req(reg_req),
    .reg_rdata(reg_rdata),
    .flash_req(flash_req),
    .flash_rdata(flash_rdata),
    .cpu_stall(cpu_stall)
);
`default_nettype wire

// ==== verification/fiap_flash_model.sv ====
// Behavioural flash array that answers the sequencer's commands.
`default_nettype none
module fiap_flash_model (
    // Clock.
    input wire logic clk,
    // Commands and read word.
    input wire fiap_pkg::fiap_flash_req_s flash_req,
    output logic [15:0] flash_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import fiap_pkg::*;
    logic [15:0] mem [0:8191];
    logic [15:0] junk = 16'hA5A5;
    // Applies page erase and word programming at the clock edge.
    always @(posedge clk) begin
        junk <= ~junk;
        if (flash_req.erase === 1'b1) begin
            for (int i = 0; i < 32; i++) begin
                mem[{flash_req.addr[12:5], i[4:0]}] = 16'h0000;
            end
        end
        if (flash_req.prog === 1'b1) begin
            mem[flash_req.addr] = flash_req.wdata;
        end
    end
    // Outside a read the data lines carry a changing pattern, never the last word.
    assign flash_rdata = (flash_req.rd === 1'b1) ? mem[flash_req.addr] : junk;
endmodule
`default_nettype wire

// ==== verification/test_flash_iap_page_write_read_sequencer.sv ====
// Self-checking bench for the flash programming sequencer.
`default_nettype none
`include "fiap_defines.svh"
module test_flash_iap_page_write_read_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import fiap_pkg::*;
    localparam int OPC = 40;
    localparam int UNL = 16;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    fiap_reg_req_s req = '0;
    logic [7:0] reg_rdata;
    fiap_flash_req_s flash_req;
    logic [15:0] flash_rdata;
    logic cpu_stall;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;
    int n_erase = 0;
    int n_prog = 0;
    // Clock of 40 ns period.
    always #20 clk = ~clk;
    fiap_top #(.OP_CYCLES(OPC), .UNLOCK_CYCLES(UNL), .PAGE_WORDS(32)) DUT (
        .clk(clk), .arst_n(arst_n), .reg_req(req), .reg_rdata(reg_rdata),
        .flash_req(flash_req), .flash_rdata(flash_rdata), .cpu_stall(cpu_stall));
    fiap_flash_model u_flash (.clk(clk), .flash_req(flash_req), .flash_rdata(flash_rdata));
    // Counts flash commands and cuts a hang short.
    always @(posedge clk) begin
        cycles++;
        if (flash_req.erase === 1'b1) n_erase++;
        if (flash_req.prog === 1'b1) n_prog++;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        #1 d = reg_rdata;
        @(posedge clk);
    endtask
    task automatic set_addr(input logic [12:0] a);
        reg_wr(`FIAP_OFS_ADDR_LOW, a[7:0]);
        reg_wr(`FIAP_OFS_ADDR_HIGH, {3'h0, a[12:8]});
    endtask
    // Waits for the stall to end and returns how many edges it lasted.
    task automatic wait_idle(output int n);
        n = 0;
        #1;
        while (cpu_stall === 1'b1 && n < 200) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 200) check("stall end", 16'h0001, 16'h0000);
        @(posedge clk);
    endtask
    task automatic t_reset();
        logic [7:0] v;
        reg_wr(8'h0C, 8'hFF);
        for (int a = 0; a < 13; a++) begin
            reg_rd(a[7:0], v);
            check("reset value", 16'h0000, {8'h00, v});
        end
    endtask
    task automatic t_read(input logic [12:0] a, input logic [15:0] e, input logic [7:0] c0);
        logic [7:0] v;
        logic [7:0] w;
        int n;
        reg_wr(`FIAP_OFS_CTRL0, c0);
        set_addr(a);
        reg_wr(`FIAP_OFS_CTRL1, 8'h02);
        wait_idle(n);
        check("read time", 16'(`FIAP_READ_CYCLES - 1), 16'(n));
        reg_rd(`FIAP_OFS_PD_LOW, v);
        reg_rd(`FIAP_OFS_PD_HIGH, w);
        check("read word", e, {w, v});
    endtask
    task automatic unlock(input logic [7:0] last, input logic exp);
        logic [7:0] k [6];
        logic [7:0] v;
        k = '{`FIAP_KEY1_LOW, `FIAP_KEY1_HIGH, `FIAP_KEY2_LOW, `FIAP_KEY2_HIGH, `FIAP_KEY3_LOW, last};
        for (int i = 0; i < 6; i++) reg_wr(`FIAP_OFS_KEY1_LOW + 8'(i), k[i]);
        reg_wr(`FIAP_OFS_CTRL0, 8'h68);
        repeat (2) @(posedge clk);
        reg_rd(`FIAP_OFS_CTRL0, v);
        check("enabled flag", 16'(exp), 16'(v[2]));
        check("protect set", 16'h0001, 16'(v[3]));
        repeat (UNL + 2) @(posedge clk);
        reg_rd(`FIAP_OFS_CTRL0, v);
        check("protect bit", 16'h0000, 16'(v[3]));
    endtask
    // Launches an erase or program and checks its length and completion.
    task automatic run_op(input int exp_pulses, input string nm);
        logic [7:0] v;
        int n;
        int p0;
        p0 = n_erase + n_prog;
        reg_wr(`FIAP_OFS_CTRL1, 8'h01);
        wait_idle(n);
        check("op time", 16'h0001, 16'(n >= OPC - 5 && n <= OPC));
        reg_rd(`FIAP_OFS_CTRL1, v);
        check("op trigger", 16'h0000, 16'(v[0]));
        check(nm, 16'(exp_pulses), 16'(n_erase + n_prog - p0));
    endtask
    task automatic t_erase();
        int n0;
        reg_wr(`FIAP_OFS_CTRL0, 8'h14);
        set_addr(13'h0127);
        n0 = n_erase;
        run_op(1, "erase pulses");
        check("erase count", 16'h0001, 16'(n_erase - n0));
        for (int i = 0; i < 32; i++) check("erased", 16'h0000, u_flash.mem[13'h0120 + i]);
    endtask
    task automatic t_prog33();
        logic [7:0] v;
        int n0;
        reg_wr(`FIAP_OFS_CTRL0, 8'h04);
        set_addr(13'h0120);
        for (int i = 0; i < 33; i++) begin
            reg_wr(`FIAP_OFS_PD_LOW, i[7:0]);
            reg_wr(`FIAP_OFS_PD_HIGH, 8'h12);
            if (i == 0) reg_rd(`FIAP_OFS_ADDR_LOW, v);
            if (i == 0) check("addr step", 16'h0021, {8'h00, v});
        end
        reg_rd(`FIAP_OFS_ADDR_LOW, v);
        check("addr saturate", 16'h003F, {8'h00, v});
        n0 = n_prog;
        run_op(32, "prog pulses");
        check("prog count", 16'd32, 16'(n_prog - n0));
        for (int i = 0; i < 32; i++) begin
            check("programmed", (i == 31) ? 16'h1220 : 16'h1200 + 16'(i), u_flash.mem[13'h0120 + i]);
        end
    endtask
    task automatic t_retry();
        int n0;
        reg_wr(`FIAP_OFS_CTRL0, 8'h04);
        reg_wr(`FIAP_OFS_CTRL1, 8'h04);
        set_addr(13'h0123);
        reg_wr(`FIAP_OFS_PD_LOW, 8'hCD);
        reg_wr(`FIAP_OFS_PD_HIGH, 8'hAB);
        n0 = n_prog;
        run_op(1, "retry pulses");
        check("retry count", 16'h0001, 16'(n_prog - n0));
        check("retry word", 16'hABCD, u_flash.mem[13'h0123]);
        check("neighbour kept", 16'h1204, u_flash.mem[13'h0124]);
    endtask
    task automatic t_relock();
        logic [7:0] v;
        int n0;
        reg_wr(`FIAP_OFS_CTRL0, 8'h10);
        reg_rd(`FIAP_OFS_CTRL0, v);
        check("relocked", 16'h0000, 16'(v[2]));
        n0 = n_erase;
        reg_wr(`FIAP_OFS_CTRL1, 8'h01);
        repeat (4) @(posedge clk);
        reg_rd(`FIAP_OFS_CTRL1, v);
        check("locked trigger", 16'h0000, 16'(v[0]));
        check("locked erase", 16'h0000, 16'(n_erase - n0));
    endtask
    // Preloads the array with non-blank contents.
    initial begin
        for (int i = 0; i < 32; i++) u_flash.mem[13'h0120 + i] = 16'hBEEF ^ 16'(i);
        u_flash.mem[13'h0055] = 16'h5AA5;
    end
    // Main sequence.
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_read(13'h0055, 16'h5AA5, 8'h32);
        unlock(8'h41, 1'b0);
        unlock(`FIAP_KEY3_HIGH, 1'b1);
        t_erase();
        t_read(13'h0123, 16'h0000, 8'h36);
        t_prog33();
        t_read(13'h013F, 16'h1220, 8'h36);
        t_retry();
        t_relock();
        wrap_up();
    end
endmodule
`default_nettype wire
